// ===== rtl/aux_cfg_if.sv
`default_nettype none
interface aux_cfg_if;
  import aux_vco_pkg::*;
  // ==========================================
  // aux port settings from the register bank, plus the muxed status level
  logic       spi_mode;    // serial port selected
  logic [2:0] gpo_value;   // static output values
  logic       level_3v3;   // drive level select
  logic [1:0] route;       // status routing
  off_mode_t  off_mode;    // disabled behaviour
  logic       status_bit;  // muxed status level
  modport ctrl  (output spi_mode, gpo_value, level_3v3, route, off_mode, status_bit);
  modport drive (input  spi_mode, gpo_value, level_3v3, route, off_mode, status_bit);
endinterface
`default_nettype wire

// ===== rtl/aux_port_drive.sv
`default_nettype none
module aux_port_drive (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // settings
  aux_cfg_if.drive        cfg,
  // serial engine
  input  wire logic       spi_active_i,
  input  wire logic [2:0] spi_out_i,
  // pins
  output logic      [2:0] pin_o,
  output logic      [2:0] oe_o,
  output logic            level_3v3_o
);
  import aux_vco_pkg::*;
  // ==========================================
  // pin state
  logic [2:0] pin_q, pin_d;  // driven values
  logic [2:0] oe_q, oe_d;    // enables
  logic       lvl_q, lvl_d;  // level select

  // next pin values
  always_comb begin
    pin_d = pin_q;
    oe_d  = 3'h7;
    lvl_d = 1'b0;
    if (!cfg.spi_mode) begin
      // static outputs
      pin_d = cfg.gpo_value;
      lvl_d = cfg.level_3v3;
    end else if (spi_active_i) begin
      // serial port running
      pin_d = spi_out_i;
    end else begin
      // serial port idle
      case (cfg.off_mode)
        OFF_HIZ:  oe_d  = 3'h0;
        OFF_HOLD: pin_d = pin_q;
        OFF_HIGH: pin_d = 3'h7;
        default:  pin_d = 3'h0;
      endcase
    end
    // status overlay on one pin
    if (cfg.route != 2'h0) begin
      pin_d[cfg.route - 2'h1] = cfg.status_bit;
      oe_d[cfg.route - 2'h1]  = 1'b1;
    end
  end

  // register pins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_q <= 3'h0;
      oe_q  <= 3'h0;
      lvl_q <= 1'b0;
    end else begin
      pin_q <= pin_d;
      oe_q  <= oe_d;
      lvl_q <= lvl_d;
    end
  end

  assign pin_o       = pin_q;
  assign oe_o        = oe_q;
  assign level_3v3_o = lvl_q;
endmodule
`default_nettype wire

// ===== rtl/aux_port_vco_divider_regs.sv
// Operation
// - mode bit picks serial port or static outputs
// - static outputs follow three value bits
// - level bit selects 1.8 V or 3.3 V, static mode only
// - sync bit makes enable pin a trigger in exact frequency mode
// - two bits route status to one output
// - calibration mode bit, resets to zero
// - apply capacitor switch and sub-band fields
// - manual tune enable bit, resets to zero
// - auto-scale pump current bit, resets one
// - divide zero mutes, one passes, even divides
// - odd rounds down, above 62 gives 62
// - first buffer gain in 3 dB steps
// - second buffer gain, same steps, reset two
// - divider stage gain, max or minus 3 dB
// - vco config reads f48a0 after reset
// - five-bit selector picks status signal
//
// Our own choice: the Wishbone interface to the registers.
`default_nettype none
module aux_port_vco_divider_regs (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // device pins and sources
  input  wire logic        chip_en_i,
  input  wire logic [31:0] status_src_i,
  input  wire logic        exact_freq_mode_i,
  // aux serial engine
  input  wire logic        aux_spi_active_i,
  input  wire logic [2:0]  aux_spi_out_i,
  // aux pins
  output logic      [2:0]  general_purpose_output_o,
  output logic      [2:0]  general_purpose_output_oe_o,
  output logic             aux_level_3v3_o,
  // phase sync
  output logic             phase_sync_o,
  // vco controls
  output logic             manual_cal_o,
  output logic      [4:0]  cap_switch_o,
  output logic      [2:0]  vco_subband_o,
  output logic             manual_tune_o,
  output logic             charge_pump_autoscale_o,
  // divider and gains
  output logic      [5:0]  div_ratio_o,
  output logic             output_mute_o,
  output logic      [1:0]  lo1_gain_o,
  output logic      [1:0]  second_local_osc_output_gain_o,
  output logic             div_stage_gain_o
);
  import aux_vco_pkg::*;

  default clocking cb @(posedge clk_i);
  endclocking

  // ==========================================
  // helpers

  // byte-lane merge into a 24-bit register
  function automatic logic [23:0] merge(
    input logic [23:0] old,
    input logic [31:0] wd,
    input logic [3:0]  sel
  );
    logic [23:0] r;
    r = old;
    for (int b = 0; b < 3; b++) begin
      if (sel[b]) begin
        r[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // ==========================================
  // state
  bus_state_t  bus_q, bus_d;    // slave phase
  logic [31:0] dat_q, dat_d;    // read data
  logic [23:0] aux_q, aux_d;    // aux_port_control
  logic [23:0] vco_q, vco_d;    // manual_vco_config
  logic [23:0] gdiv_q, gdiv_d;  // gain_divider
  logic [4:0]  ssel_q, ssel_d;  // status selector
  logic [5:0]  idx;             // word index
  logic        req;             // live request
  logic [23:0] state_word;      // live state view

  // ==========================================
  // pin synchronisers
  logic [31:0] st_meta_q, st_sync_q;   // status sources
  logic        ce_meta_q, ce_sync_q;   // enable pin
  logic        ce_prev_q;              // edge history
  logic        stat_q, stat_d;         // selected status
  logic        psync_q, psync_d;       // sync trigger

  aux_cfg_if cfg ();
  logic [2:0] pins;  // driven aux values
  logic [2:0] oes;   // aux enables

  assign idx = wb_adr_i[7:2];
  assign req = wb_cyc_i && wb_stb_i;

  // live state for the read-only word
  assign state_word = {10'h000, oes, pins, stat_q, output_mute_o, div_ratio_o};

  // ==========================================
  // bus and registers

  // next values of bus and register bank
  always_comb begin
    bus_d  = bus_q;
    dat_d  = dat_q;
    aux_d  = aux_q;
    vco_d  = vco_q;
    gdiv_d = gdiv_q;
    ssel_d = ssel_q;
    case (bus_q)
      BUS_IDLE: begin
        // take request, fetch read data
        if (req) begin
          bus_d = BUS_ACK;
          if (idx == IDX_AUX_CTRL) begin
            dat_d = {8'h00, aux_q};
          end else if (idx == IDX_VCO_CFG) begin
            dat_d = {8'h00, vco_q};
          end else if (idx == IDX_GAIN_DIV) begin
            dat_d = {8'h00, gdiv_q};
          end else if (idx == IDX_STAT_SEL) begin
            dat_d = {27'h0000000, ssel_q};
          end else if (idx == IDX_STATE) begin
            dat_d = {8'h00, state_word};
          end else begin
            dat_d = 32'h00000000;  // unmapped
          end
        end
      end
      BUS_ACK: begin
        // write lands on the acked edge
        bus_d = BUS_IDLE;
        if (req && wb_we_i) begin
          // reserved bits stored as written
          if (idx == IDX_AUX_CTRL) begin
            aux_d = merge(aux_q, wb_dat_i, wb_sel_i);
          end else if (idx == IDX_VCO_CFG) begin
            vco_d = merge(vco_q, wb_dat_i, wb_sel_i);
          end else if (idx == IDX_GAIN_DIV) begin
            gdiv_d = merge(gdiv_q, wb_dat_i, wb_sel_i);
          end else if (idx == IDX_STAT_SEL && wb_sel_i[0]) begin
            ssel_d = wb_dat_i[4:0];
          end
        end
      end
      default: bus_d = BUS_IDLE;
    endcase
  end

  // register bus and bank
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bus_q  <= BUS_IDLE;
      dat_q  <= 32'h00000000;
      aux_q  <= AUX_CTRL_RST;
      vco_q  <= VCO_CFG_RST;
      gdiv_q <= GAIN_DIV_RST;
      ssel_q <= STAT_SEL_RST;
    end else begin
      bus_q  <= bus_d;
      dat_q  <= dat_d;
      aux_q  <= aux_d;
      vco_q  <= vco_d;
      gdiv_q <= gdiv_d;
      ssel_q <= ssel_d;
    end
  end

  assign wb_ack_o = (bus_q == BUS_ACK);
  assign wb_dat_o = dat_q;

  // ==========================================
  // status mux and phase sync

  // pick status, detect trigger edge
  always_comb begin
    stat_d  = st_sync_q[ssel_q];
    psync_d = ce_sync_q && !ce_prev_q && aux_q[PSYNC_BIT]
              && exact_freq_mode_i;
  end

  // two-stage pin sampling
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_meta_q <= 32'h00000000;
      st_sync_q <= 32'h00000000;
      // enable history starts high: a pin already high at reset gives no false edge
      ce_meta_q <= 1'b1;
      ce_sync_q <= 1'b1;
      ce_prev_q <= 1'b1;
      stat_q    <= 1'b0;
      psync_q   <= 1'b0;
    end else begin
      st_meta_q <= status_src_i;
      st_sync_q <= st_meta_q;
      ce_meta_q <= chip_en_i;
      ce_sync_q <= ce_meta_q;
      ce_prev_q <= ce_sync_q;
      stat_q    <= stat_d;
      psync_q   <= psync_d;
    end
  end

  assign phase_sync_o = psync_q;

  // ==========================================
  // aux port
  assign cfg.spi_mode   = aux_q[AUX_MODE_BIT];
  assign cfg.gpo_value  = aux_q[AUX_VAL_LSB +: 3];
  assign cfg.level_3v3  = aux_q[AUX_LVL_BIT];
  assign cfg.route      = aux_q[ROUTE_LSB +: 2];
  assign cfg.off_mode   = off_mode_t'(aux_q[OFF_LSB +: 2]);
  assign cfg.status_bit = stat_q;

  // pin driver
  aux_port_drive u_drive (
    .clk_i        (clk_i),
    .rst_i        (rst_i),
    .cfg          (cfg.drive),
    .spi_active_i (aux_spi_active_i),
    .spi_out_i    (aux_spi_out_i),
    .pin_o        (pins),
    .oe_o         (oes),
    .level_3v3_o  (aux_level_3v3_o)
  );

  assign general_purpose_output_o    = pins;
  assign general_purpose_output_oe_o = oes;

  // ==========================================
  // vco controls
  assign manual_cal_o            = vco_q[MCAL_BIT];
  assign cap_switch_o            = vco_q[CAP_LSB +: 5];
  assign vco_subband_o           = vco_q[SUB_LSB +: 3];
  assign manual_tune_o           = vco_q[MTUNE_BIT];
  assign charge_pump_autoscale_o = vco_q[ASCALE_BIT];

  // ==========================================
  // divider and gains
  divide_decode #(
    .W (6)
  ) u_div (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .field_i (gdiv_q[DIV_LSB +: 6]),
    .ratio_o (div_ratio_o),
    .mute_o  (output_mute_o)
  );

  assign lo1_gain_o                     = gdiv_q[G1_LSB +: 2];
  assign second_local_osc_output_gain_o = gdiv_q[G2_LSB +: 2];
  assign div_stage_gain_o               = gdiv_q[DSG_BIT];

  // ==========================================
  // checks

  AST_STATIC_DRIVE: assert property (
    disable iff (rst_i)
    (!aux_q[AUX_MODE_BIT] && aux_q[ROUTE_LSB +: 2] == 2'h0)
    |=> (oes == 3'h7 && pins == $past(aux_q[AUX_VAL_LSB +: 3])))
    else $error("static outputs not driven from value bits");

  AST_LEVEL: assert property (
    disable iff (rst_i)
    !aux_q[AUX_MODE_BIT] |=> aux_level_3v3_o == $past(aux_q[AUX_LVL_BIT]))
    else $error("drive level does not follow level bit");

  AST_PSYNC: assert property (
    disable iff (rst_i)
    phase_sync_o |-> ($past(aux_q[PSYNC_BIT]) && $past(exact_freq_mode_i)
                      && $past(ce_sync_q) && !$past(ce_prev_q)))
    else $error("phase sync trigger without armed enable edge");

  AST_ROUTE0: assert property (
    disable iff (rst_i)
    aux_q[ROUTE_LSB +: 2] == 2'h1 |=> (pins[0] == $past(stat_q) && oes[0]))
    else $error("status not routed to aux output 0");

  AST_OFF_HIGH: assert property (
    disable iff (rst_i)
    (aux_q[AUX_MODE_BIT] && !aux_spi_active_i && aux_q[OFF_LSB +: 2] == 2'h2
     && aux_q[ROUTE_LSB +: 2] == 2'h0) |=> (pins == 3'h7 && oes == 3'h7))
    else $error("idle port not forced high");

  AST_MUTE: assert property (
    disable iff (rst_i)
    gdiv_q[DIV_LSB +: 6] == 6'h00 |=> output_mute_o)
    else $error("divide zero did not mute");

  AST_ODD_DOWN: assert property (
    disable iff (rst_i)
    (gdiv_q[0] && gdiv_q[5:0] > 6'h01 && gdiv_q[5:0] < 6'h3f)
    |=> div_ratio_o == $past(gdiv_q[5:0]) - 6'h01)
    else $error("odd ratio not rounded down");

  AST_RESET_VCO: assert property (
    rst_i |=> vco_q == 24'h0f48a0)
    else $error("vco config not f48a0 after reset");

  AST_STATUS_SEL: assert property (
    disable iff (rst_i)
    !$past(rst_i) |-> stat_q == $past(st_sync_q[ssel_q]))
    else $error("status bit not from selected source");

  AST_ACK_DROP: assert property (
    disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held two cycles");
endmodule
`default_nettype wire

// ===== rtl/aux_vco_pkg.sv
`default_nettype none
package aux_vco_pkg;
  // ==========================================
  // register indices (byte address = 4 * index)
  localparam logic [5:0]  IDX_AUX_CTRL = 6'h14;  // aux_port_control
  localparam logic [5:0]  IDX_VCO_CFG  = 6'h15;  // manual_vco_config
  localparam logic [5:0]  IDX_GAIN_DIV = 6'h16;  // gain_divider
  localparam logic [5:0]  IDX_STAT_SEL = 6'h1b;  // status selector
  localparam logic [5:0]  IDX_STATE    = 6'h1c;  // live state, read only
  // ==========================================
  // values after reset
  localparam logic [23:0] AUX_CTRL_RST = 24'h000220;
  localparam logic [23:0] VCO_CFG_RST  = 24'h0f48a0;
  localparam logic [23:0] GAIN_DIV_RST = 24'h0006c1;
  localparam logic [4:0]  STAT_SEL_RST = 5'h01;  // lock detect
  // ==========================================
  // field positions
  localparam int AUX_MODE_BIT = 0;   // serial port / static outputs
  localparam int AUX_VAL_LSB  = 1;   // static values [3:1]
  localparam int AUX_LVL_BIT  = 4;   // 3.3 V level
  localparam int PSYNC_BIT    = 9;   // enable pin as sync trigger
  localparam int ROUTE_LSB    = 10;  // status routing [11:10]
  localparam int OFF_LSB      = 12;  // disabled behaviour [13:12]
  localparam int MCAL_BIT     = 0;   // manual calibration
  localparam int CAP_LSB      = 1;   // capacitor switch [5:1]
  localparam int SUB_LSB      = 6;   // core sub-band [8:6]
  localparam int MTUNE_BIT    = 9;   // manual tune
  localparam int ASCALE_BIT   = 16;  // pump current auto-scale
  localparam int DIV_LSB      = 0;   // divide ratio [5:0]
  localparam int G1_LSB       = 6;   // first buffer gain [7:6]
  localparam int G2_LSB       = 8;   // second buffer gain [9:8]
  localparam int DSG_BIT      = 10;  // divider stage gain
  // ==========================================
  // divider limits
  localparam logic [5:0]  DIV_MAX = 6'h3e;  // 62
  // ==========================================
  // types
  typedef enum logic [1:0] {
    OFF_HIZ  = 2'b00,
    OFF_HOLD = 2'b01,
    OFF_HIGH = 2'b10,
    OFF_LOW  = 2'b11
  } off_mode_t;
  typedef enum logic [0:0] {
    BUS_IDLE = 1'b0,
    BUS_ACK  = 1'b1
  } bus_state_t;
endpackage
`default_nettype wire

// ===== rtl/divide_decode.sv
`default_nettype none
module divide_decode #(
  parameter int W = 6  // ratio field width
) (
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // raw field
  input  wire logic [W-1:0] field_i,
  // decoded ratio
  output logic      [W-1:0] ratio_o,
  output logic              mute_o
);
  import aux_vco_pkg::*;
  // ==========================================
  // decode state
  logic [W-1:0] ratio_q, ratio_d;  // effective ratio
  logic         mute_q, mute_d;    // output stages off

  // clamp and round down
  always_comb begin
    mute_d  = (field_i == '0);
    ratio_d = field_i;
    if (field_i > W'(DIV_MAX)) begin
      ratio_d = W'(DIV_MAX);
    end else if (field_i > W'(1) && field_i[0]) begin
      ratio_d = field_i - W'(1);
    end
  end

  // register result
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ratio_q <= W'(1);
      mute_q  <= 1'b0;
    end else begin
      ratio_q <= ratio_d;
      mute_q  <= mute_d;
    end
  end

  assign ratio_o = ratio_q;
  assign mute_o  = mute_q;
endmodule
`default_nettype wire

// ===== testbench/aux_wire_model.sv
`default_nettype none
module aux_wire_model (
  // clock
  input  wire logic       clk_i,
  // aux pins from the device
  input  wire logic [2:0] pin_i,
  input  wire logic [2:0] oe_i,
  // levels seen by the external devices
  output logic      [2:0] wire_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================
  // line resolution
  logic [2:0] last_q = 3'h0;  // last level each line was driven to
  // released lines show the inverse of their last level, never a stale copy
  always_comb begin
    wire_o = (oe_i & pin_i) | (~oe_i & ~last_q);
  end
  // remember driven levels only
  always_ff @(posedge clk_i) begin
    last_q <= (oe_i & pin_i) | (~oe_i & last_q);
  end
endmodule
`default_nettype wire

// ===== testbench/tb_top.sv
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import aux_vco_pkg::*;
  // ==========================================
  // stimulus
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [3:0]  wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h0;
  logic        chip_en_i = 1'b0;
  logic [31:0] status_src_i = 32'h0;
  logic        exact_freq_mode_i = 1'b0;
  logic        aux_spi_active_i = 1'b0;
  logic [2:0]  aux_spi_out_i = 3'h0;
  // ==========================================
  // observed
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic [2:0]  general_purpose_output, gpo_oe, aux_wire;
  logic        lvl, psync, mcal, mtune, ascale, mute, dsg;
  logic [4:0]  cap;
  logic [2:0]  sub;
  logic [5:0]  ratio;
  logic [1:0]  g1, g2;
  int          num_errors = 0;
  int          n_compared = 0;
  always #20 clk_i = ~clk_i;
  aux_port_vco_divider_regs u_aux_port_vco_divider_regs (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .chip_en_i(chip_en_i), .status_src_i(status_src_i), .exact_freq_mode_i(exact_freq_mode_i),
    .aux_spi_active_i(aux_spi_active_i), .aux_spi_out_i(aux_spi_out_i),
    .general_purpose_output_o(general_purpose_output), .general_purpose_output_oe_o(gpo_oe),
    .aux_level_3v3_o(lvl), .phase_sync_o(psync), .manual_cal_o(mcal), .cap_switch_o(cap),
    .vco_subband_o(sub), .manual_tune_o(mtune), .charge_pump_autoscale_o(ascale),
    .div_ratio_o(ratio), .output_mute_o(mute), .lo1_gain_o(g1),
    .second_local_osc_output_gain_o(g2), .div_stage_gain_o(dsg));
  aux_wire_model u_aux_wire_model (.clk_i(clk_i), .pin_i(general_purpose_output), .oe_i(gpo_oe), .wire_o(aux_wire));
  // ==========================================
  // shared helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  // one classic cycle, waits for ack under a bound
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int n;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    n = 0;
    // flops update by nba, so right after the edge we see the sampled ack
    do begin @(posedge clk_i); n++; end while (wb_ack_o !== 1'b1 && n < 50);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
    chk(n < 50, 1'b1, "bus answer");
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string m);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    chk(q, e, m);
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk_i);
    @(negedge clk_i);
  endtask
  // ==========================================
  // scenarios
  task automatic t_reset();
    rd_chk(8'h54, 32'h000f48a0, "vco cfg reset");
    rd_chk(8'h58, 32'h000006c1, "gain reset");
    rd_chk(8'h7c, 32'h0, "unmapped read");
    chk({mcal, cap, sub, mtune, ascale}, {1'b0, 5'h10, 3'h2, 1'b0, 1'b1}, "vco");
    chk({g1, g2, dsg, ratio, mute}, {2'h3, 2'h2, 1'b1, 6'h01, 1'b0}, "gain");
  endtask
  task automatic t_vco();
    wr(8'h54, 32'h000e4b7f);
    settle(2);
    chk({mcal, cap, sub, mtune, ascale}, {1'b1, 5'h1f, 3'h5, 1'b1, 1'b0}, "vco set");
    rd_chk(8'h54, 32'h000e4b7f, "vco readback");
  endtask
  task automatic t_gpo();
    logic [2:0] v;
    for (int i = 0; i < 2; i++) begin
      v = i ? 3'b010 : 3'b101;
      wr(8'h50, 32'h20 | (32'(v) << 1) | (32'(v[0]) << 4));
      settle(2);
      chk({general_purpose_output, gpo_oe, lvl}, {v, 3'b111, v[0]}, "static outputs");
    end
  endtask
  task automatic t_off();
    logic [2:0] ep [3] = '{3'b000, 3'b111, 3'b000};
    logic [2:0] eo [3] = '{3'b000, 3'b111, 3'b111};
    @(posedge clk_i);
    aux_spi_active_i <= 1'b1;
    aux_spi_out_i    <= 3'b110;
    wr(8'h50, 32'h00001031);
    settle(2);
    chk({general_purpose_output, lvl}, {3'b110, 1'b0}, "serial drive");
    @(posedge clk_i);
    aux_spi_active_i <= 1'b0;
    settle(2);
    chk({general_purpose_output, gpo_oe, aux_wire}, {3'b110, 3'b111, 3'b110}, "hold");
    for (int m = 0; m < 3; m++) begin
      wr(8'h50, 32'h21 | (32'(m == 0 ? 0 : m + 1) << 12));
      settle(2);
      chk(gpo_oe, eo[m], "idle enables");
      if (m != 0) chk(general_purpose_output, ep[m], "idle level");
    end
  endtask
  task automatic t_div();
    logic [5:0] f [10] = '{1, 2, 3, 4, 5, 6, 60, 61, 62, 63};
    logic [5:0] e [10] = '{1, 2, 2, 4, 4, 6, 60, 60, 62, 62};
    wr(8'h58, 32'h6c0);
    settle(2);
    chk(mute, 1'b1, "mute");
    for (int i = 0; i < 10; i++) begin
      wr(8'h58, 32'h6c0 | 32'(f[i]));
      settle(2);
      chk({ratio, mute}, {e[i], 1'b0}, "ratio");
    end
    // live state: oe 111, pins 000, status 0, no mute, ratio 62
    rd_chk(8'h70, 32'h0000383e, "state word");
  endtask
  task automatic t_gain();
    for (int g = 0; g < 4; g++) begin
      wr(8'h58, 32'h1 | (32'(g) << 6) | (32'(3 - g) << 8) | (32'(g & 1) << 10));
      settle(2);
      chk({g1, g2, dsg}, {2'(g), 2'(3 - g), 1'(g & 1)}, "gains");
    end
  endtask
  task automatic t_route();
    @(posedge clk_i);
    status_src_i <= 32'h2;
    for (int r = 0; r < 4; r++) begin
      wr(8'h50, 32'h20 | (32'(r) << 10));
      settle(6);
      chk(general_purpose_output, r == 0 ? 3'b000 : 3'(1 << (r - 1)), "route");
    end
    wr(8'h6c, 32'h5);
    rd_chk(8'h6c, 32'h5, "selector readback");
    wr(8'h50, 32'h420);
    settle(6);
    chk(general_purpose_output[0], 1'b0, "selector off");
    @(posedge clk_i);
    status_src_i <= 32'h20;
    settle(6);
    chk(general_purpose_output[0], 1'b1, "selector on");
  endtask
  task automatic pulses(input logic ex, input logic [31:0] e, input string m);
    int c;
    c = 0;
    @(posedge clk_i);
    exact_freq_mode_i <= ex;
    settle(3);
    @(posedge clk_i);
    chip_en_i <= 1'b1;
    repeat (10) begin @(negedge clk_i); c += int'(psync === 1'b1); end
    chk(c, e, m);
    @(posedge clk_i);
    chip_en_i <= 1'b0;
    settle(6);
  endtask
  task automatic t_psync();
    wr(8'h50, 32'h220);
    pulses(1'b1, 1, "sync pulse");
    pulses(1'b0, 0, "sync needs exact mode");
    wr(8'h50, 32'h020);
    pulses(1'b1, 0, "sync bit clear");
  endtask
  // ==========================================
  // verdict
  task automatic conclude();
    $display("compared %0d, errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_vco();
    t_gpo();
    t_off();
    t_div();
    t_gain();
    t_route();
    t_psync();
    conclude();
  end
  // watchdog
  initial begin
    repeat (5000) @(posedge clk_i);
    num_errors++;
    conclude();
  end
endmodule
`default_nettype wire
